// ### src/link_param_regs.sv
// Register bank for GPIO read-back and link transmit parameters.
// Assumes a byte register port, read data one cycle after the strobe,
// gain-port pins driven through three-signal pin ports, and a framer
// that reads its link configuration from the cfg output.
//
// How it works
// [R01] Output read-back register shows sampled levels of forced GPIO output pins.
// [R02] An enabled output pin reads back its actual external level.
// [R03] Input read-back register shows sampled levels of GPIO input pins.
// [R04] Writable device id and four-bit bank id; upper bank bits read zero.
// [R05] Bit 7 enables scrambling; lane code 0 one lane, 1 two lanes.
// [R06] Octet code 1 means two octets, 3 four; resets to four.
// [R07] Multiframe length is frames field plus one; resets to 32.
// [R08] Converter code 1 means two I/Q converters; that is the reset.
// [R09] Software keeps samples-per-frame at zero, one sample per frame.
// [R10] Two writable five-bit lane ids, resetting to zero and one.
// [R11] Two writable eight-bit lane checksums, resetting to 0x44 and 0x45.
// [R12] Lane FIFO start bit releases framer data; zero blocks hand-off.
// [R13] Software sets the start bit only after setup and power-up.
// [R14] Pin is GPIO only when forced; direction one output, zero input.
// [R15] Framer receives all stored parameters for its link configuration.
`timescale 1ns/1ns
module link_param_regs (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// Register port.
	input  wire logic [8:0]       regAddr,
	input  wire logic [7:0]       regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [7:0]       regRdata,
	// Gain-port pins, shared with the gain-control function.
	input  wire logic [3:0]       gainPinIn,
	output logic      [3:0]       gainPinOut,
	output logic      [3:0]       gainPinOe,
	input  wire logic [3:0]       gainFuncOut,
	input  wire logic [3:0]       gainFuncOe,
	// Framer link configuration and multiframe length.
	output link_regs_pkg::link_cfg_t linkCfg,
	output logic      [5:0]       framesPerMulti,
	// Framer to PHY lane path.
	input  wire logic [7:0]       frmData [2],
	input  wire logic             frmValid,
	output logic      [7:0]       phyData [2],
	output logic      [1:0]       phyValid
);

	logic       rstMeta_b;
	logic       rstSync_b;
	link_regs_pkg::reg_req_t req;

	logic [7:0] devId_q;
	logic [3:0] bankId_q;
	logic       scramble_q;
	logic [4:0] laneCode_q;
	logic [7:0] octetCode_q;
	logic [4:0] frameCode_q;
	logic [7:0] convCode_q;
	logic [4:0] sampleCode_q;
	logic [7:0] spareOne_q;
	logic [7:0] spareTwo_q;
	logic [4:0] lane0Id_q;
	logic [4:0] lane1Id_q;
	logic [7:0] lane0Chk_q;
	logic [7:0] lane1Chk_q;
	logic       fifoStart_q;
	logic [3:0] gpioForce_q;
	logic [3:0] gpioDir_q;
	logic [3:0] gpioVal_q;
	logic [3:0] pinLevel;
	logic [3:0] gpoRead;
	logic [3:0] gpiRead;
	logic [7:0] rdata_d;

	// Reset is applied at once and released through two flops so every
	// flop leaves reset on the same clean edge.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// Bundle the port so decode reads one carrier.
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// Link identifiers; bank bits above the nibble are not stored.
	// [R04] identifier storage
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			devId_q  <= link_regs_pkg::RST_ZERO;
			bankId_q <= link_regs_pkg::RST_ZERO[3:0];
		end else if (req.wr) begin
			if (req.addr == link_regs_pkg::OFS_DEV_ID) begin
				devId_q <= req.wdata;
			end
			if (req.addr == link_regs_pkg::OFS_BANK_ID) begin
				bankId_q <= req.wdata[link_regs_pkg::NIB_MSB:0];
			end
		end
	end

	// Lane count and scrambling flag share one register.
	// [R05] lane and scramble
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			scramble_q <= 1'b0;
			laneCode_q <= link_regs_pkg::RST_ZERO[4:0];
		end else if (req.wr && req.addr == link_regs_pkg::OFS_LANE_SCR) begin
			scramble_q <= req.wdata[link_regs_pkg::SCR_BIT];
			laneCode_q <= req.wdata[link_regs_pkg::LANE_MSB:0];
		end
	end

	// Frame shape parameters.
	// [R06] octets per frame
	// [R07] frames field
	// [R08] converter count
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			octetCode_q  <= link_regs_pkg::RST_OCTETS;
			frameCode_q  <= link_regs_pkg::RST_FRAMES;
			convCode_q   <= link_regs_pkg::RST_CONV;
			sampleCode_q <= link_regs_pkg::RST_ZERO[4:0];
		end else if (req.wr) begin
			case (req.addr)
				link_regs_pkg::OFS_OCTETS: begin
					octetCode_q <= req.wdata;
				end
				link_regs_pkg::OFS_FRAMES: begin
					frameCode_q <= req.wdata[link_regs_pkg::FIELD5_MSB:0];
				end
				link_regs_pkg::OFS_CONV: begin
					convCode_q <= req.wdata;
				end
				// [R09] stored as written
				link_regs_pkg::OFS_SAMPLES: begin
					sampleCode_q <= req.wdata[link_regs_pkg::FIELD5_MSB:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Spare link bytes are plain storage carried into the configuration.
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			spareOne_q <= link_regs_pkg::RST_ZERO;
			spareTwo_q <= link_regs_pkg::RST_ZERO;
		end else if (req.wr) begin
			if (req.addr == link_regs_pkg::OFS_SPARE_ONE) begin
				spareOne_q <= req.wdata;
			end
			if (req.addr == link_regs_pkg::OFS_SPARE_TWO) begin
				spareTwo_q <= req.wdata;
			end
		end
	end

	// Per-lane identifiers and checksums.
	// [R10] lane identifiers
	// [R11] lane checksums
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			lane0Id_q  <= link_regs_pkg::RST_LANE0;
			lane1Id_q  <= link_regs_pkg::RST_LANE1;
			lane0Chk_q <= link_regs_pkg::RST_CHK0;
			lane1Chk_q <= link_regs_pkg::RST_CHK1;
		end else if (req.wr) begin
			case (req.addr)
				link_regs_pkg::OFS_LANE0_ID: begin
					lane0Id_q <= req.wdata[link_regs_pkg::FIELD5_MSB:0];
				end
				link_regs_pkg::OFS_LANE1_ID: begin
					lane1Id_q <= req.wdata[link_regs_pkg::FIELD5_MSB:0];
				end
				link_regs_pkg::OFS_LANE0_CHK: begin
					lane0Chk_q <= req.wdata;
				end
				link_regs_pkg::OFS_LANE1_CHK: begin
					lane1Chk_q <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Lane FIFO start bit; only bit zero is kept.
	// [R12] start bit storage
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			fifoStart_q <= 1'b0;
		end else if (req.wr && req.addr == link_regs_pkg::OFS_FIFO_START) begin
			fifoStart_q <= req.wdata[link_regs_pkg::FIFO_BIT];
		end
	end

	// GPIO setup registers that steer the shared pins.
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			gpioForce_q <= link_regs_pkg::RST_ZERO[3:0];
			gpioDir_q   <= link_regs_pkg::RST_ZERO[3:0];
			gpioVal_q   <= link_regs_pkg::RST_ZERO[3:0];
		end else if (req.wr) begin
			case (req.addr)
				link_regs_pkg::OFS_GPIO_FORCE: begin
					gpioForce_q <= req.wdata[link_regs_pkg::NIB_MSB:0];
				end
				link_regs_pkg::OFS_GPIO_DIR: begin
					gpioDir_q <= req.wdata[link_regs_pkg::NIB_MSB:0];
				end
				link_regs_pkg::OFS_GPIO_VAL: begin
					gpioVal_q <= req.wdata[link_regs_pkg::NIB_MSB:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Pin muxing: a forced pin is GPIO, otherwise the gain function owns it.
	// [R14] force and direction
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (gpioForce_q[i]) begin
				gainPinOut[i] = gpioVal_q[i];
				gainPinOe[i]  = gpioDir_q[i];
			end else begin
				gainPinOut[i] = gainFuncOut[i];
				gainPinOe[i]  = gainFuncOe[i];
			end
		end
	end

	// The pins come from outside the clock domain.
	pin_sync uPinSync (
		.ref_clk   (ref_clk),
		.rstSync_b (rstSync_b),
		.pinIn     (gainPinIn),
		.pinOut    (pinLevel)
	);

	// Read-back takes the pad level, so a shorted output shows the truth.
	// [R01] output read-back
	// [R02] pad level
	assign gpoRead = pinLevel & gpioForce_q & gpioDir_q;
	// [R03] input read-back
	assign gpiRead = pinLevel & gpioForce_q & ~gpioDir_q;

	// Read mux; unmapped offsets read zero.
	always_comb begin
		case (req.addr)
			link_regs_pkg::OFS_GPO_READ:   rdata_d = {4'h0, gpoRead};
			link_regs_pkg::OFS_GPI_READ:   rdata_d = {4'h0, gpiRead};
			link_regs_pkg::OFS_GPIO_FORCE: rdata_d = {4'h0, gpioForce_q};
			link_regs_pkg::OFS_GPIO_DIR:   rdata_d = {4'h0, gpioDir_q};
			link_regs_pkg::OFS_GPIO_VAL:   rdata_d = {4'h0, gpioVal_q};
			link_regs_pkg::OFS_DEV_ID:     rdata_d = devId_q;
			link_regs_pkg::OFS_BANK_ID:    rdata_d = {4'h0, bankId_q};
			link_regs_pkg::OFS_LANE_SCR: begin
				rdata_d = {scramble_q, 2'h0, laneCode_q};
			end
			link_regs_pkg::OFS_OCTETS:     rdata_d = octetCode_q;
			link_regs_pkg::OFS_FRAMES:     rdata_d = {3'h0, frameCode_q};
			link_regs_pkg::OFS_CONV:       rdata_d = convCode_q;
			link_regs_pkg::OFS_SAMPLES:    rdata_d = {3'h0, sampleCode_q};
			link_regs_pkg::OFS_SPARE_ONE:  rdata_d = spareOne_q;
			link_regs_pkg::OFS_SPARE_TWO:  rdata_d = spareTwo_q;
			link_regs_pkg::OFS_LANE0_ID:   rdata_d = {3'h0, lane0Id_q};
			link_regs_pkg::OFS_LANE1_ID:   rdata_d = {3'h0, lane1Id_q};
			link_regs_pkg::OFS_LANE0_CHK:  rdata_d = lane0Chk_q;
			link_regs_pkg::OFS_LANE1_CHK:  rdata_d = lane1Chk_q;
			link_regs_pkg::OFS_FIFO_START: rdata_d = {7'h00, fifoStart_q};
			default:                       rdata_d = link_regs_pkg::READ_ZERO;
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			regRdata <= link_regs_pkg::READ_ZERO;
		end else if (req.rd) begin
			regRdata <= rdata_d;
		end else begin
			regRdata <= link_regs_pkg::READ_ZERO;
		end
	end

	// Parameters the framer places in its lane alignment configuration.
	// [R15] configuration to framer
	assign linkCfg = '{
		devId:      devId_q,
		bankId:     bankId_q,
		scramble:   scramble_q,
		laneCode:   laneCode_q,
		octetCode:  octetCode_q,
		frameCode:  frameCode_q,
		convCode:   convCode_q,
		sampleCode: sampleCode_q,
		spareOne:   spareOne_q,
		spareTwo:   spareTwo_q,
		laneIds:    {lane1Id_q, lane0Id_q},
		laneChk:    {lane1Chk_q, lane0Chk_q}
	};

	// Multiframe length in frames, one more than the stored field.
	// [R07] length plus one
	assign framesPerMulti = {1'b0, frameCode_q} + 6'h01;

	// Hand-off to the PHY; no readiness check, since setup order is
	// software's duty before setting the start bit.
	// [R12] gated hand-off
	// [R13] relies on setup order
	lane_gate uLaneGate (
		.ref_clk   (ref_clk),
		.rstSync_b (rstSync_b),
		.start     (fifoStart_q),
		.twoLanes  (laneCode_q == link_regs_pkg::LANES_TWO),
		.frmData   (frmData),
		.frmValid  (frmValid),
		.phyData   (phyData),
		.phyValid  (phyValid)
	);

endmodule : link_param_regs

// ### common/link_regs_pkg.sv
// Package for the GPIO read-back and link parameter register bank.
// Assumes a byte-wide register port addressed by a nine-bit offset.
package link_regs_pkg;

	// Register port widths, pin count and lane count.
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int PIN_N  = 4;
	localparam int LANE_N = 2;

	// Register offsets.
	localparam logic [8:0] OFS_GPO_READ   = 9'h1b3;
	localparam logic [8:0] OFS_GPI_READ   = 9'h1b4;
	localparam logic [8:0] OFS_DEV_ID     = 9'h1c0;
	localparam logic [8:0] OFS_BANK_ID    = 9'h1c1;
	localparam logic [8:0] OFS_LANE_SCR   = 9'h1c3;
	localparam logic [8:0] OFS_OCTETS     = 9'h1c4;
	localparam logic [8:0] OFS_FRAMES     = 9'h1c5;
	localparam logic [8:0] OFS_CONV       = 9'h1c6;
	localparam logic [8:0] OFS_SAMPLES    = 9'h1c9;
	localparam logic [8:0] OFS_SPARE_ONE  = 9'h1cb;
	localparam logic [8:0] OFS_SPARE_TWO  = 9'h1cc;
	localparam logic [8:0] OFS_LANE0_ID   = 9'h1d0;
	localparam logic [8:0] OFS_LANE1_ID   = 9'h1d1;
	localparam logic [8:0] OFS_LANE0_CHK  = 9'h1d8;
	localparam logic [8:0] OFS_LANE1_CHK  = 9'h1d9;
	localparam logic [8:0] OFS_FIFO_START = 9'h1e0;
	localparam logic [8:0] OFS_GPIO_FORCE = 9'h1b0;
	localparam logic [8:0] OFS_GPIO_DIR   = 9'h1b1;
	localparam logic [8:0] OFS_GPIO_VAL   = 9'h1b2;

	// Field positions.
	localparam int SCR_BIT    = 7;
	localparam int LANE_MSB   = 4;
	localparam int FIELD5_MSB = 4;
	localparam int NIB_MSB    = 3;
	localparam int FIFO_BIT   = 0;

	// Reset values and the two-lane code.
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] RST_OCTETS  = 8'h03;
	localparam logic [4:0] RST_FRAMES  = 5'h1f;
	localparam logic [7:0] RST_CONV    = 8'h01;
	localparam logic [4:0] RST_LANE0   = 5'h00;
	localparam logic [4:0] RST_LANE1   = 5'h01;
	localparam logic [7:0] RST_CHK0    = 8'h44;
	localparam logic [7:0] RST_CHK1    = 8'h45;
	localparam logic [4:0] LANES_TWO   = 5'h01;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// Link parameters as handed to the framer.
	typedef struct packed {
		logic [7:0]  devId;
		logic [3:0]  bankId;
		logic        scramble;
		logic [4:0]  laneCode;
		logic [7:0]  octetCode;
		logic [4:0]  frameCode;
		logic [7:0]  convCode;
		logic [4:0]  sampleCode;
		logic [7:0]  spareOne;
		logic [7:0]  spareTwo;
		logic [9:0]  laneIds;
		logic [15:0] laneChk;
	} link_cfg_t;

	// One register port request.
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage : link_regs_pkg

// ### src/pin_sync.sv
// Three-stage synchroniser with agreement filter for the gain-port pins.
// Assumes pins are asynchronous to ref_clk; output lags by four edges.
`timescale 1ns/1ns
module pin_sync (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rstSync_b,
	// Pin levels in and filtered levels out.
	input  wire logic [3:0]       pinIn,
	output logic      [3:0]       pinOut
);

	logic [3:0] stageA;
	logic [3:0] stageB;
	logic [3:0] stageC;

	// Each pin passes three flops; a change counts only once B and C agree.
	genvar g;
	for (g = 0; g < 4; g++) begin : gSync
		always_ff @(posedge ref_clk or negedge rstSync_b) begin
			if (!rstSync_b) begin
				stageA[g] <= 1'b0;
				stageB[g] <= 1'b0;
				stageC[g] <= 1'b0;
				pinOut[g] <= 1'b0;
			end else begin
				stageA[g] <= pinIn[g];
				stageB[g] <= stageA[g];
				stageC[g] <= stageB[g];
				if (stageB[g] == stageC[g]) begin
					pinOut[g] <= stageC[g];
				end
			end
		end
	end

endmodule : pin_sync

// ### src/lane_gate.sv
// Lane hand-off gate between the framer and the transmitter PHY.
// Assumes framer data is valid per cycle; the PHY never stalls.
`timescale 1ns/1ns
module lane_gate (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rstSync_b,
	// Control.
	input  wire logic             start,
	input  wire logic             twoLanes,
	// Framer side.
	input  wire logic [7:0]       frmData [2],
	input  wire logic             frmValid,
	// PHY side.
	output logic      [7:0]       phyData [2],
	output logic      [1:0]       phyValid
);

	// Lanes only hand off data while started; the second lane's valid also
	// needs the two-lane code, but its data byte follows the framer on every framer-valid cycle while started.
	genvar g;
	for (g = 0; g < 2; g++) begin : gLane
		always_ff @(posedge ref_clk or negedge rstSync_b) begin
			if (!rstSync_b) begin
				phyData[g]  <= 8'h00;
				phyValid[g] <= 1'b0;
			end else begin
				phyValid[g] <= start && frmValid && (g == 0 || twoLanes);
				if (start && frmValid) begin
					phyData[g] <= frmData[g];
				end
			end
		end
	end

endmodule : lane_gate

// ### tb/link_regs_checker_assertions.sv
// Concurrent checks on the link parameter register bank's top ports.
// Assumes one clock domain and the bank's registered read port.
`timescale 1ns/1ns
module link_regs_checker (
	// Clock and reset.
	input logic                     ref_clk,
	input logic                     rst_b,
	// Register port.
	input logic [8:0]               regAddr,
	input logic [7:0]               regWdata,
	input logic                     regWr,
	input logic                     regRd,
	input logic [7:0]               regRdata,
	// Framer configuration and lane path.
	input link_regs_pkg::link_cfg_t linkCfg,
	input logic [5:0]               framesPerMulti,
	input logic [7:0]               frmData [2],
	input logic                     frmValid,
	input logic [7:0]               phyData [2],
	input logic [1:0]               phyValid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	logic [7:0] wdQ;
	logic [7:0] frmQ;

	// Last cycle's write data and lane 0 byte, so fields can be sliced.
	always_ff @(posedge ref_clk) begin
		wdQ  <= regWdata;
		frmQ <= frmData[0];
	end

	property p_rd_idle;
		!$past(regRd) |-> regRdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read answer");

	property p_bank_rsv;
		$past(regRd) && $past(regAddr) == link_regs_pkg::OFS_BANK_ID
			|-> regRdata[7:4] == 4'h0;
	endproperty
	a_bank_rsv: assert property (p_bank_rsv)
		else $error("bank register upper bits not zero");

	property p_devid;
		regWr && regAddr == link_regs_pkg::OFS_DEV_ID
			|=> linkCfg.devId == wdQ;
	endproperty
	a_devid: assert property (p_devid)
		else $error("device id not stored");

	property p_bankid;
		regWr && regAddr == link_regs_pkg::OFS_BANK_ID
			|=> linkCfg.bankId == wdQ[3:0];
	endproperty
	a_bankid: assert property (p_bankid)
		else $error("bank id not stored");

	property p_lane_scr;
		regWr && regAddr == link_regs_pkg::OFS_LANE_SCR
			|=> linkCfg.scramble == wdQ[7] && linkCfg.laneCode == wdQ[4:0];
	endproperty
	a_lane_scr: assert property (p_lane_scr)
		else $error("lane count or scramble flag not stored");

	property p_octets;
		regWr && regAddr == link_regs_pkg::OFS_OCTETS
			|=> linkCfg.octetCode == wdQ;
	endproperty
	a_octets: assert property (p_octets)
		else $error("octet code not stored");

	property p_frames;
		$stable(linkCfg.frameCode)
			|-> framesPerMulti == {1'b0, linkCfg.frameCode} + 6'd1;
	endproperty
	a_frames: assert property (p_frames)
		else $error("multiframe length not frames field plus one");

	property p_conv;
		regWr && regAddr == link_regs_pkg::OFS_CONV
			|=> linkCfg.convCode == wdQ;
	endproperty
	a_conv: assert property (p_conv)
		else $error("converter code not stored");

	property p_gate;
		!$past(frmValid) |-> phyValid == 2'b00;
	endproperty
	a_gate: assert property (p_gate)
		else $error("lane beat without framer data");

	property p_lane1;
		phyValid[1] |-> $past(linkCfg.laneCode) == link_regs_pkg::LANES_TWO;
	endproperty
	a_lane1: assert property (p_lane1)
		else $error("second lane active in one lane mode");

	property p_lane0_data;
		phyValid[0] |-> phyData[0] == frmQ;
	endproperty
	a_lane0_data: assert property (p_lane0_data)
		else $error("lane 0 byte differs from framer byte");
endmodule : link_regs_checker

bind link_param_regs link_regs_checker u_chk (.ref_clk, .rst_b, .regAddr,
	.regWdata, .regWr, .regRd, .regRdata, .linkCfg, .framesPerMulti,
	.frmData, .frmValid, .phyData, .phyValid);

// ### tb/host_lane_sink.sv
// Host receiver side: lane sink and board-level pad of the shared pins.
// Assumes the PHY never stalls, so every valid beat is taken at once.
`timescale 1ns/1ns
module host_lane_sink (
	// Clock.
	input  logic       ref_clk,
	// Lanes from the transmitter.
	input  logic [7:0] phyData [2],
	input  logic [1:0] phyValid,
	// Shared pins: device drive and board level.
	input  logic [3:0] pinOut,
	input  logic [3:0] pinOe,
	input  logic [3:0] extLevel,
	output logic [3:0] padLevel,
	// Beat counts and last bytes per lane.
	output int         beats [2],
	output logic [7:0] lastByte [2]
);
	// The device wins where it drives; elsewhere the board level shows.
	assign padLevel = (pinOe & pinOut) | (~pinOe & extLevel);

	// Take every valid beat; an unknown valid is not counted.
	initial beats = '{0, 0};
	always @(posedge ref_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (phyValid[i] === 1'b1) begin
				beats[i]    <= beats[i] + 1;
				lastByte[i] <= phyData[i];
			end
		end
	end
endmodule : host_lane_sink

// ### tb/testbench.sv
// Self-checking bench for the link parameter register bank.
// Assumes the bind in the checker file and the host sink model.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
	errors++; $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
	typedef struct {logic [8:0] a; logic [7:0] rv, wv, rb;} row_t;
	logic ref_clk, rst_b, regWr, regRd, frmValid;
	logic [8:0] regAddr;
	logic [7:0] regWdata, regRdata, d;
	logic [3:0] gainPinIn, gainPinOut, gainPinOe, extLevel;
	logic [3:0] gainFuncOut, gainFuncOe;
	logic [7:0] frmData [2];
	logic [7:0] phyData [2];
	logic [7:0] lastByte [2];
	logic [1:0] phyValid;
	logic [5:0] framesPerMulti;
	link_regs_pkg::link_cfg_t linkCfg;
	int beats [2];
	int errors, cmp_count, b1;
	// Address, reset value, value written, value read back.
	row_t rows [17] = '{
		'{9'h1c0, 8'h00, 8'ha5, 8'ha5}, '{9'h1c1, 8'h00, 8'hff, 8'h0f},
		'{9'h1c3, 8'h00, 8'he1, 8'h81}, '{9'h1c4, 8'h03, 8'h01, 8'h01},
		'{9'h1c5, 8'h1f, 8'h2a, 8'h0a}, '{9'h1c6, 8'h01, 8'h01, 8'h01},
		'{9'h1c9, 8'h00, 8'h00, 8'h00}, '{9'h1cb, 8'h00, 8'h5a, 8'h5a},
		'{9'h1cc, 8'h00, 8'hc3, 8'hc3}, '{9'h1d0, 8'h00, 8'hff, 8'h1f},
		'{9'h1d1, 8'h01, 8'h1e, 8'h1e}, '{9'h1d8, 8'h44, 8'hbb, 8'hbb},
		'{9'h1d9, 8'h45, 8'h12, 8'h12}, '{9'h1e0, 8'h00, 8'h00, 8'h00},
		'{9'h1b3, 8'h00, 8'hff, 8'h00}, '{9'h1b4, 8'h00, 8'hff, 8'h00},
		'{9'h1ff, 8'h00, 8'h77, 8'h00}};

	link_param_regs DUT (.ref_clk, .rst_b, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .gainPinIn, .gainPinOut, .gainPinOe,
		.gainFuncOut, .gainFuncOe, .linkCfg, .framesPerMulti, .frmData,
		.frmValid, .phyData, .phyValid);
	host_lane_sink u_sink (.ref_clk, .phyData, .phyValid,
		.pinOut(gainPinOut), .pinOe(gainPinOe), .extLevel,
		.padLevel(gainPinIn), .beats, .lastByte);

	// Free-running 250 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// One write cycle, then one idle cycle so strobes never collide.
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	// One read cycle; the answer is taken in the cycle after the strobe.
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 v = regRdata;
		@(posedge ref_clk);
	endtask : rd

	// Prints the counts and the verdict, then stops the run.
	task final_report;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// A hang is cut short well past the expected run length.
	initial begin
		repeat (3000) @(posedge ref_clk);
		errors++;
		final_report();
	end

	// Main sequence: reset, register table, then the awkward cases.
	initial begin
		rst_b = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 9'h000;
		regWdata = 8'h00; frmValid = 1'b0; frmData = '{8'h00, 8'h00};
		extLevel = 4'b1010; gainFuncOut = 4'b0100; gainFuncOe = 4'b0100;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK("frames reset", 6'd32, framesPerMulti)
		`CHK("pin oe unforced", 4'b0100, gainPinOe)
		// Software keeps samples at zero and the start bit low here.
		foreach (rows[i]) begin
			rd(rows[i].a, d);
			`CHK("reset value", rows[i].rv, d)
			wr(rows[i].a, rows[i].wv);
			rd(rows[i].a, d);
			`CHK("read back", rows[i].rb, d)
		end
		`CHK("frames", 6'd11, framesPerMulti)
		// No beat while the start bit is clear.
		frmValid   <= 1'b1;
		frmData[0] <= 8'h11;
		frmData[1] <= 8'h22;
		repeat (4) @(posedge ref_clk);
		`CHK("beats stopped", 0, beats[0] + beats[1])
		// start only after all parameters are set
		wr(link_regs_pkg::OFS_FIFO_START, 8'h01);
		repeat (3) @(posedge ref_clk);
		`CHK("lane 0 byte", 8'h11, lastByte[0])
		`CHK("lane 1 byte", 8'h22, lastByte[1])
		wr(link_regs_pkg::OFS_LANE_SCR, 8'h00);
		#1 b1 = beats[1];
		frmData[0] <= 8'h33;
		repeat (4) @(posedge ref_clk);
		`CHK("one lane", b1, beats[1])
		`CHK("lane 0 new", 8'h33, lastByte[0])
		// Pins 0 and 1 driven as outputs, pins 2 and 3 read as inputs.
		wr(link_regs_pkg::OFS_GPIO_FORCE, 8'h0f);
		wr(link_regs_pkg::OFS_GPIO_DIR, 8'h03);
		wr(link_regs_pkg::OFS_GPIO_VAL, 8'h01);
		`CHK("pin oe forced", 4'b0011, gainPinOe)
		`CHK("pin drive", 2'b01, gainPinOut[1:0])
		repeat (6) @(posedge ref_clk);
		rd(link_regs_pkg::OFS_GPO_READ, d);
		`CHK("output read-back", 8'h01, d)
		rd(link_regs_pkg::OFS_GPI_READ, d);
		`CHK("input read-back", 8'h08, d)
		// Back-to-back write then read must see the new checksum.
		regAddr  <= link_regs_pkg::OFS_LANE1_CHK;
		regWdata <= 8'h9c;
		regWr    <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 `CHK("checksum", 8'h9c, regRdata)
		@(posedge ref_clk);
		final_report();
	end
endmodule : testbench
